// ---- core/flash_rww_boot_lock_guard.sv ----
// Flash access guard: read-while-write split, core halt and boot lock fields
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
//
// Contract
// [R01] Read block chosen by section of the programming address, not read address.
// [R02] Programming the readable section keeps other-section reads alive, no halt.
// [R03] Software never reads readable section while it is programmed.
// [R04] Software disables interrupts or moves vectors during such programming.
// [R05] Boot loader section always lies inside the no-read section.
// [R06] Busy flag reads one while readable section is blocked.
// [R07] Software clears busy flag before using readable-section code.
// [R08] Programming the no-read section halts the core for the whole operation.
// [R09] Two lock fields, application and boot, set independently.
// [R10] Lock bits programmed by software or programmer, cleared by chip erase only. Reset also restores them to unprogrammed here.
// [R11] General write lock does not affect store instruction programming.
// [R12] General read/write lock does not affect flash load or store.
// [R13] Application field 11: no restriction.
// [R14] Application field 10: writes refused, loads allowed.
// [R15] Application field 00: writes and boot-code loads refused.
// [R16] Application field 01: boot-code loads refused, writes allowed.
// [R17] App modes 3,4 with boot vectors: interrupts off in application code.
// [R18] Boot field 11: no restriction.
// [R19] Boot field 10: writes to boot section refused.
// [R20] Boot field 00: writes and application-code loads refused.
// [R21] Boot field 01: app-code loads refused; modes 3,4 mask boot-side interrupts.
// [R22] Busy flag set when erase or write of readable section begins.
// [R23] Busy cleared by read-enable with store-enable when idle, or page load.
// [R24] Locks checked on every store and load; refusals have no side effect. Page-load and lock-set stores skip the check here.
module flash_rww_boot_lock_guard (
    input  wire logic                               ref_clk,
    input  wire logic                               nrst,

    // Register port
    input  wire logic [3:0]                         reg_addr,
    input  wire logic [7:0]                         reg_wdata,
    input  wire logic                               reg_write,
    input  wire logic                               reg_read,
    output logic      [7:0]                         reg_rdata,

    // Store requests from the core
    input  wire logic                               store_req,
    input  wire flash_guard_pkg::store_op_t         store_op,
    input  wire logic [flash_guard_pkg::ADDR_W-1:0] store_addr,
    input  wire logic [3:0]                         store_lock_data,
    // Origin of the running code
    input  wire logic [flash_guard_pkg::ADDR_W-1:0] exec_pc,

    // Flash load requests
    input  wire logic                               load_req,
    input  wire logic [flash_guard_pkg::ADDR_W-1:0] load_addr,

    // Flash array side
    input  wire logic                               flash_done,
    output logic                                    flash_start,
    output logic      [flash_guard_pkg::OP_W-1:0]   flash_op,
    output logic      [flash_guard_pkg::ADDR_W-1:0] flash_addr,
    output logic                                    load_grant,
    output logic                                    load_refused,
    output logic                                    store_refused,
    output logic                                    section_busy_flag,
    output logic                                    cpu_halt,
    output logic                                    irq_suppress,

    // General lock mode inputs, deliberately ignored by this guard
    input  wire logic [1:0]                         general_lock
);
    import flash_guard_pkg::*;

    // Array phase
    typedef enum logic [1:0] {IDLE, PROG_READABLE, PROG_NO_READ} prog_state_t;

    typedef struct packed {
        // Control and locks
        prog_state_t             state;
        logic                    busy;
        logic                    store_en;
        logic [1:0]              app_lock;
        logic [1:0]              boot_lock;
        logic [1:0]              boot_sz;
        logic                    vec_boot;

        // Registered outputs
        logic [7:0]              rdata;
        logic                    start;
        logic [OP_W-1:0]         op;
        logic [ADDR_W-1:0]       addr;
        logic                    grant;
        logic                    lrefused;
        logic                    srefused;
        logic                    halt;
        logic                    irq_off;
    } guard_t;

    // Present and next state
    guard_t r;
    guard_t next_r;

    // ---------------------------------------------------------------
    // Section decode
    // ---------------------------------------------------------------
    // Boot start from the size code
    // Larger code, smaller section
    function automatic logic [ADDR_W-1:0] boot_start(input logic [1:0] sz);
        unique case (sz)
            2'h0: boot_start = BOOT_START_0;
            2'h1: boot_start = BOOT_START_1;
            2'h2: boot_start = BOOT_START_2;
            2'h3: boot_start = BOOT_START_3;
        endcase
    endfunction

    // [R05] boot within no-read
    // Every boot start sits at or above the split, so boot implies no-read
    // Also holds if a boot start is lowered
    function automatic logic in_boot(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
        in_boot = (a >= boot_start(sz)) && (a >= NO_READ_START);
    endfunction

    // Fixed section split
    function automatic logic in_no_read(input logic [ADDR_W-1:0] a);
        in_no_read = (a >= NO_READ_START);
    endfunction

    // Store refused by the lock field of the targeted section
    function automatic logic write_locked(input logic boot_tgt, input logic [1:0] app,
                                          input logic [1:0] boot);
        // [R14] app lower bit blocks writes
        // [R19] boot lower bit blocks writes
        write_locked = boot_tgt ? !boot[0] : !app[0];
    endfunction

    // Load refused when crossing sections against an upper lock bit
    // Same-section loads always pass
    function automatic logic read_locked(input logic boot_tgt, input logic boot_pc,
                                         input logic [1:0] app, input logic [1:0] boot);
        // [R15] [R16] app upper bit blocks boot-code loads
        // [R20] [R21] boot upper bit blocks app-code loads
        if (boot_tgt && !boot_pc) begin
            read_locked = !boot[1];
        end else if (!boot_tgt && boot_pc) begin
            read_locked = !app[1];
        end else begin
            read_locked = 1'b0;
        end
    endfunction

    // Section of each request
    logic st_boot;
    logic st_no_read;
    logic pc_boot;
    logic ld_boot;
    logic st_locked;
    logic ld_locked;

    // Classify addresses of the current requests
    // Decoded in the arrival cycle
    always_comb begin
        st_boot   = in_boot(store_addr, r.boot_sz);
        st_no_read = in_no_read(store_addr);
        // Origin of running code
        pc_boot   = in_boot(exec_pc, r.boot_sz);
        ld_boot   = in_boot(load_addr, r.boot_sz);

        // [R11] [R12] general lock not used
        // [R13] [R18] unprogrammed fields never refuse
        st_locked = write_locked(st_boot, r.app_lock, r.boot_lock);
        ld_locked = read_locked(ld_boot, pc_boot, r.app_lock, r.boot_lock);
    end

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    // Pulses default low
    always_comb begin
        next_r          = r;
        next_r.start    = 1'b0;
        next_r.grant    = 1'b0;
        next_r.lrefused = 1'b0;
        next_r.srefused = 1'b0;
        next_r.rdata    = 8'h00;

        // Register writes
        // Writes first, so a set below wins
        if (reg_write) begin
            unique case (reg_addr)
                REG_CTRL: begin
                    // [R23] clear busy only when idle
                    // Ignored while the array works
                    if (reg_wdata[CTRL_READ_EN] && reg_wdata[CTRL_STORE_EN]
                        && r.state == IDLE) begin
                        next_r.busy = 1'b0;
                    end
                    next_r.store_en = reg_wdata[CTRL_STORE_EN];
                end

                REG_LOCK: begin
                    // [R10] software only programs bits to zero
                    // [R09] fields independent
                    // Erase restores unprogrammed
                    if (reg_wdata[LOCK_ERASE]) begin
                        next_r.app_lock  = LOCK_RESET;
                        next_r.boot_lock = LOCK_RESET;
                    end else begin
                        next_r.app_lock  = r.app_lock
                                           & reg_wdata[LOCK_APP_HI:LOCK_APP_LO];
                        next_r.boot_lock = r.boot_lock
                                           & reg_wdata[LOCK_BOOT_HI:LOCK_BOOT_LO];
                    end
                end

                REG_CONFIG: begin
                    next_r.boot_sz  = reg_wdata[CFG_BOOT_SZ+1:CFG_BOOT_SZ];
                    next_r.vec_boot = reg_wdata[CFG_VEC_BOOT];
                end

                default: ;
            endcase
        end

        // Register reads, data stand one cycle later
        // Zero in every other cycle
        if (reg_read) begin
            unique case (reg_addr)
                REG_CTRL: begin
                    // [R06] busy reads one while blocked
                    next_r.rdata[CTRL_BUSY]     = r.busy;
                    next_r.rdata[CTRL_STORE_EN] = r.store_en;
                end

                REG_LOCK:   next_r.rdata = {4'h0, r.boot_lock, r.app_lock};
                REG_CONFIG: next_r.rdata = {5'h00, r.vec_boot, r.boot_sz};
                REG_STATUS: next_r.rdata = {4'h0, r.halt, r.busy, 2'(r.state)};
                default:    next_r.rdata = 8'h00;
            endcase
        end

        // Programming sequence
        // Stores ignored while the array works
        unique case (r.state)
            IDLE: begin
                if (store_req) begin
                    // [R24] locked store dropped, only store_refused pulses
                    if (store_op == OP_LOCK_SET) begin
                        // [R10] store programs lock bits
                        // Never touches the array
                        next_r.app_lock  = next_r.app_lock & store_lock_data[1:0];
                        next_r.boot_lock = next_r.boot_lock & store_lock_data[3:2];
                    end else if (store_op == OP_PAGE_LOAD) begin
                        // [R23] page load clears busy
                        next_r.busy  = 1'b0;
                        next_r.start = 1'b1;
                        next_r.op    = store_op;
                        next_r.addr  = store_addr;
                    end else if (st_locked) begin
                        next_r.srefused = 1'b1;
                    end else begin
                        next_r.start = 1'b1;
                        next_r.op    = store_op;
                        next_r.addr  = store_addr;
                        // [R01] section of target address
                        // Read address plays no part
                        if (st_no_read) begin
                            // [R08] halt for whole operation
                            next_r.halt  = 1'b1;
                            next_r.state = PROG_NO_READ;
                        end else begin
                            // [R22] busy set at start
                            // [R02] no halt
                            // No-read code keeps running
                            next_r.busy  = 1'b1;
                            next_r.state = PROG_READABLE;
                        end
                    end
                end
            end

            // Busy stays until cleared
            PROG_READABLE: begin
                if (flash_done) begin
                    next_r.state = IDLE;
                end
            end

            // Core released after done
            PROG_NO_READ: begin
                if (flash_done) begin
                    next_r.halt  = 1'b0;
                    next_r.state = IDLE;
                end
            end

            default: next_r.state = IDLE;
        endcase

        // Flash loads; readable section stays blocked while busy
        if (load_req) begin
            // [R24] refused load has no side effect
            // Answered in any state
            if (ld_locked || (r.busy && !in_no_read(load_addr))) begin
                next_r.lrefused = 1'b1;
            end else begin
                next_r.grant = 1'b1;
            end
        end

        // [R17] [R21] interrupts off in the locked section
        // One cycle behind the code
        next_r.irq_off = (r.vec_boot && !pc_boot && !r.app_lock[1])
                       || (!r.vec_boot && pc_boot && !r.boot_lock[1]);
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    // Locks reset unprogrammed
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            r           <= '0;
            r.state     <= IDLE;
            r.app_lock  <= LOCK_RESET;
            r.boot_lock <= LOCK_RESET;
            r.boot_sz   <= BOOT_SZ_RST;
        end else begin
            // Whole state moves at once
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata         = r.rdata;

    // Flash array side
    assign flash_start       = r.start;
    assign flash_op          = r.op;
    assign flash_addr        = r.addr;

    // Answers to the core
    assign load_grant        = r.grant;
    assign load_refused      = r.lrefused;
    assign store_refused     = r.srefused;
    assign section_busy_flag = r.busy;
    assign cpu_halt          = r.halt;
    assign irq_suppress      = r.irq_off;

endmodule // flash_rww_boot_lock_guard

// ---- core/flash_guard_pkg.sv ----
// Constants and types shared by the flash access guard
package flash_guard_pkg;

    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int ADDR_W = 15;  // Word address width of program flash
    localparam int OP_W   = 2;

    // ---------------------------------------------------------------
    // Section limits (word addresses); boot size is selected by a 2-bit code
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] NO_READ_START = 15'h7000;
    localparam logic [ADDR_W-1:0] BOOT_START_0 = 15'h7000;  // Largest boot section
    localparam logic [ADDR_W-1:0] BOOT_START_1 = 15'h7800;
    localparam logic [ADDR_W-1:0] BOOT_START_2 = 15'h7C00;
    localparam logic [ADDR_W-1:0] BOOT_START_3 = 15'h7E00;  // Smallest boot section

    // ---------------------------------------------------------------
    // Register map of the plain register port
    // ---------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;  // Store control and busy flag
    localparam logic [3:0] REG_LOCK   = 4'h1;  // Lock fields
    localparam logic [3:0] REG_CONFIG = 4'h2;  // Boot size and vector placement
    localparam logic [3:0] REG_STATUS = 4'h3;  // Guard state

    // Control register fields
    localparam int CTRL_STORE_EN  = 0;
    localparam int CTRL_READ_EN   = 4;
    localparam int CTRL_BUSY      = 6;
    // Lock register fields
    localparam int LOCK_APP_LO    = 0;
    localparam int LOCK_APP_HI    = 1;
    localparam int LOCK_BOOT_LO   = 2;
    localparam int LOCK_BOOT_HI   = 3;
    localparam int LOCK_ERASE     = 7;  // Write one: chip erase of lock fields
    // Config register fields
    localparam int CFG_BOOT_SZ    = 0;
    localparam int CFG_VEC_BOOT   = 2;

    // Reset values
    localparam logic [1:0] LOCK_RESET   = 2'h3;  // Unprogrammed
    localparam logic [1:0] BOOT_SZ_RST  = 2'h0;

    // ---------------------------------------------------------------
    // Store operation codes
    // ---------------------------------------------------------------
    typedef enum logic [OP_W-1:0] {
        OP_PAGE_LOAD  = 2'h0,
        OP_PAGE_ERASE = 2'h1,
        OP_PAGE_WRITE = 2'h2,
        OP_LOCK_SET   = 2'h3
    } store_op_t;

endpackage

// ---- sim/flash_guard_asserts.sv ----
// Port checker for the flash access guard, bound onto the guard
`timescale 1ns/1ns
module flash_guard_asserts import flash_guard_pkg::*; (
    input wire logic              ref_clk,
    input wire logic              nrst,
    input wire logic [3:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_write,
    input wire logic              store_req,
    input wire logic              load_req,
    input wire logic [ADDR_W-1:0] load_addr,
    input wire logic              flash_done,
    input wire logic              flash_start,
    input wire logic [OP_W-1:0]   flash_op,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic              load_grant,
    input wire logic              load_refused,
    input wire logic              store_refused,
    input wire logic              section_busy_flag,
    input wire logic              cpu_halt
);
    // ------------------------------------------------------------
    // Helpers: erase or write in flight, and a busy-clear request
    // ------------------------------------------------------------
    logic pend;
    wire  prog = flash_start && (flash_op == OP_PAGE_ERASE || flash_op == OP_PAGE_WRITE);
    wire  clr  = reg_write && !store_req && reg_addr == REG_CTRL
                 && reg_wdata[CTRL_READ_EN] && reg_wdata[CTRL_STORE_EN];

    // Dropped by the done pulse so a clear is only judged once idle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) pend <= 1'b0;
        else if (flash_done) pend <= 1'b0;
        else if (prog) pend <= 1'b1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_no_read_halt: assert property (prog && flash_addr >= NO_READ_START |-> cpu_halt)
        else $error("Core not halted for no-read section programming");
    a_readable_runs: assert property (prog && flash_addr < NO_READ_START
        |-> !cpu_halt && section_busy_flag)
        else $error("Readable section write handled wrong");
    a_halt_hold: assert property (cpu_halt && !flash_done |=> cpu_halt)
        else $error("Halt dropped before the array finished");
    a_halt_drop: assert property (cpu_halt && flash_done |=> !cpu_halt)
        else $error("Halt kept after the array finished");
    a_busy_hold: assert property (section_busy_flag && !store_req && !reg_write
        |=> section_busy_flag) else $error("Busy flag fell with no clear");
    a_busy_clear: assert property (clr && !pend && !flash_done |=> !section_busy_flag)
        else $error("Busy flag not cleared by idle clear write");
    a_load_once: assert property (load_req |=> load_grant != load_refused)
        else $error("Load not answered by exactly one of grant and refuse");
    a_load_block: assert property (load_req && section_busy_flag
        && load_addr < NO_READ_START |=> load_refused)
        else $error("Blocked section load was granted");
    a_quiet_refuse: assert property (store_refused
        |-> !flash_start && $stable(section_busy_flag))
        else $error("Refused store had a side effect");
endmodule // flash_guard_asserts

bind flash_rww_boot_lock_guard flash_guard_asserts chk_u (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .store_req(store_req), .load_req(load_req),
    .load_addr(load_addr), .flash_done(flash_done), .flash_start(flash_start),
    .flash_op(flash_op), .flash_addr(flash_addr), .load_grant(load_grant),
    .load_refused(load_refused), .store_refused(store_refused),
    .section_busy_flag(section_busy_flag), .cpu_halt(cpu_halt));

// ---- sim/flash_array_model.sv ----
// Behavioural flash array that answers each start with one done pulse
`timescale 1ns/1ns
module flash_array_model (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic flash_start,
    input  wire logic slow,
    output logic      flash_done
);
    int cnt;

    // Busy time is short or long per operation, so both waits get exercised
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (cnt == 1);
            if (flash_start) cnt <= slow ? 40 : 3;
            else if (cnt > 0) cnt <= cnt - 1;
        end
    end
endmodule // flash_array_model

// ---- sim/flash_rww_boot_lock_guard_tb.sv ----
// Self-checking bench for the flash access guard
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); end end
module flash_rww_boot_lock_guard_tb;
    import flash_guard_pkg::*;
    logic              ref_clk, nrst, reg_write, reg_read, store_req, load_req, slow, busy;
    logic              flash_done, flash_start, load_grant, load_refused, store_refused;
    logic              section_busy_flag, cpu_halt, irq_suppress;
    logic [3:0]        reg_addr, store_lock_data;
    logic [7:0]        reg_wdata, reg_rdata, d;
    logic [1:0]        flash_op, general_lock, app_lk, boot_lk;
    logic [ADDR_W-1:0] store_addr, exec_pc, load_addr, flash_addr;
    logic [31:0]       seed, r;
    store_op_t         store_op;
    int                mismatches, n_checks, bs, v;
    int                bs_tab[4] = '{BOOT_START_0, BOOT_START_1, BOOT_START_2, BOOT_START_3};

    flash_rww_boot_lock_guard dut_u (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .store_req(store_req), .store_op(store_op), .store_addr(store_addr),
        .store_lock_data(store_lock_data), .exec_pc(exec_pc), .load_req(load_req),
        .load_addr(load_addr), .flash_done(flash_done), .flash_start(flash_start),
        .flash_op(flash_op), .flash_addr(flash_addr), .load_grant(load_grant),
        .load_refused(load_refused), .store_refused(store_refused),
        .section_busy_flag(section_busy_flag), .cpu_halt(cpu_halt),
        .irq_suppress(irq_suppress), .general_lock(general_lock));
    flash_array_model far_u (.ref_clk(ref_clk), .nrst(nrst), .flash_start(flash_start),
        .slow(slow), .flash_done(flash_done));

    // --------------------------------------------------------------
    // Clock, random source and bus tasks
    // --------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] wd);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= wd;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Store requests always come from boot code, the only place allowed to program
    task automatic req(input store_op_t op, input int a, input logic [3:0] ld);
        @(posedge ref_clk);
        store_req <= 1'b1;
        store_op <= op;
        store_addr <= a[14:0];
        store_lock_data <= ld;
        exec_pc <= 15'h7F00;
        @(posedge ref_clk);
        store_req <= 1'b0;
        #1;
    endtask

    task automatic wait_done();
        int i;
        i = 0;
        while (!flash_done && i < 100) begin
            @(posedge ref_clk);
            #1 i++;
        end
        `CHK(flash_done, 1'b1)
        @(posedge ref_clk);
        #1 `CHK(cpu_halt, 1'b0)
    endtask

    // Erase or write, checked against the lock model; optionally run to completion
    task automatic prog(input store_op_t op, input int a, input logic wt);
        logic ok;
        ok = (a >= bs) ? boot_lk[0] : app_lk[0];
        req(op, a, 4'hF);
        `CHK(store_refused, !ok)
        `CHK(flash_start, ok)
        `CHK(cpu_halt, ok && a >= NO_READ_START)
        if (ok && a < NO_READ_START) busy = 1'b1;
        `CHK(section_busy_flag, busy)
        if (ok && wt) begin
            wait_done();
            // Clear before touching readable code again
            reg_wr(REG_CTRL, 8'h11);
            busy = 1'b0;
            `CHK(section_busy_flag, 1'b0)
        end
    endtask

    task automatic load(input int a, input int pc);
        logic no;
        no = (busy && a < NO_READ_START) || (pc >= bs && a < bs && !app_lk[1])
             || (pc < bs && a >= bs && !boot_lk[1]);
        @(posedge ref_clk);
        load_req <= 1'b1;
        load_addr <= a[14:0];
        exec_pc <= pc[14:0];
        @(posedge ref_clk);
        load_req <= 1'b0;
        #1 `CHK(load_refused, no)
        `CHK(load_grant, !no)
    endtask

    task automatic irq(input int pc, input logic e);
        @(posedge ref_clk);
        exec_pc <= pc[14:0];
        repeat (2) @(posedge ref_clk);
        #1 `CHK(irq_suppress, e)
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard, far above the length of the sequence
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        print_verdict();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        {nrst, reg_write, reg_read, store_req, load_req, slow, busy} = '0;
        {reg_addr, reg_wdata, store_addr, store_lock_data, load_addr, general_lock} = '0;
        store_op = OP_PAGE_LOAD;
        exec_pc = 15'h7F00;
        seed = 32'd2995;
        mismatches = 0;
        n_checks = 0;
        {boot_lk, app_lk} = 4'hF;
        bs = BOOT_START_0;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        reg_rd(REG_LOCK);
        `CHK(d[3:0], 4'hF)
        reg_rd(REG_CTRL);
        `CHK(d[CTRL_BUSY], 1'b0)
        reg_wr(4'hF, 8'hFF);
        reg_rd(4'hF);
        `CHK(d, 8'h00)
        $display("test registers done");
        // Readable section write: no-read code keeps running, clear refused mid-write
        slow <= 1'b1;
        prog(OP_PAGE_WRITE, 'h0100, 1'b0);
        load('h7200, 'h7100);
        load('h0100, 'h7100);
        reg_rd(REG_CTRL);
        `CHK(d[CTRL_BUSY], 1'b1)
        reg_wr(REG_CTRL, 8'h11);
        `CHK(section_busy_flag, 1'b1)
        wait_done();
        `CHK(section_busy_flag, 1'b1)
        reg_wr(REG_CTRL, 8'h11);
        busy = 1'b0;
        `CHK(section_busy_flag, 1'b0)
        load('h0100, 'h0200);
        prog(OP_PAGE_ERASE, 'h0200, 1'b0);
        wait_done();
        req(OP_PAGE_LOAD, 'h0200, 4'hF);
        busy = 1'b0;
        if (flash_start) wait_done();
        `CHK(section_busy_flag, 1'b0)
        $display("test read-while-write done");
        // Every lock combination with random boot size, vectors and general lock
        for (v = 0; v < 16; v++) begin
            r = rnd();
            slow <= r[3];
            general_lock <= r[5:4];
            reg_wr(REG_CONFIG, {5'h0, r[2:0]});
            bs = bs_tab[r[1:0]];
            reg_wr(REG_LOCK, 8'h80);
            req(OP_LOCK_SET, r[14:0], v[3:0]);
            req(OP_LOCK_SET, r[14:0], 4'hF);
            reg_wr(REG_LOCK, 8'h0F);
            {boot_lk, app_lk} = v[3:0];
            reg_rd(REG_LOCK);
            `CHK(d[3:0], v[3:0])
            prog(OP_PAGE_ERASE, r[13:0], 1'b1);
            prog(OP_PAGE_WRITE, bs + r[8:0], 1'b1);
            load(r[12:0], 'h7F00);
            load(bs + r[8:0], 'h0400);
            load(r[13:0], 'h0400);
            irq('h0400, !app_lk[1] && r[2]);
            irq('h7F00, !boot_lk[1] && !r[2]);
        end
        $display("test lock modes done");
        print_verdict();
    end
endmodule // flash_rww_boot_lock_guard_tb
